// ---- core/axis_io_safety_logic.sv ----
/*
 * Per-axis input and output supervision: fault, home, limit and capture inputs; enable, disable,
 * compare and current/direction outputs; APB register slave.
 * Assumes pins are synchronous-capable levels, open-collector pins are modelled as plain levels
 * where a low output means sinking, and the motion core supplies direction, following-error and
 * compare/index events as single-cycle pulses.
 */
// Contract
// - Drive fault input level is readable in the axis status word.
// - With shutdown enabled, a fault disables axis until cleared and re-enabled.
// - Position and velocity modes stop only when moving toward the active limit.
// - Contour mode stops on either active limit regardless of direction.
// - Torque mode ignores both travel limits.
// - Limits individually enabled; stop action is decelerate, abrupt stop or switch off.
// - Capture starts on the rising edge of the capture input.
// - Capture pulses of at least 100 ns are recognised.
// - Capture readable as digital input; compare drivable as digital output.
// - Servo axis accepts index as zero only while home input is active.
// - Stepper axis zeroes on activation of the home input.
// - Pulse-command homing stays tied to its dedicated home input.
// - Drive disable sinks while disabled or in reset; releases at once when on.
// - Any axis error asserts drive disable.
// - Amplifier enable sinks while enabled; released on off or reset.
// - Any axis error deasserts amplifier enable.
// - Compare output flags each compare event, polarity configurable, default high.
// - One-shot compare pulse lasts 1 ms within half a millisecond.
// - Compare retriggers up to 4 kHz servo, 1 kHz stepper.
// - Current output rests high, driven low when full current selected.
// - Unipolar servo mode puts command direction on the shared output.
`timescale 1ns/1ps
`include "axis_io_map.svh"

module axis_io_safety_logic
    import axis_io_pkg::*;
(
    // APB clock, reset and slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Axis input pins, active high after the opto stage.
    input wire logic fault_in,
    input wire logic home_in,
    input wire logic limit_pos_in,
    input wire logic limit_neg_in,
    input wire logic capture_in,
    // Motion core.
    input wire logic move_pos,
    input wire logic move_neg,
    input wire logic following_err,
    input wire logic index_pulse,
    input wire logic compare_hit,
    input wire logic cmd_dir_neg,
    output logic stop_decel_req,
    output logic stop_abrupt_req,
    output logic capture_strobe,
    output logic zero_set,
    // Axis output pins; low means sinking.
    output logic amp_enable_n,
    output logic drive_disable_n,
    output logic compare_out,
    output logic current_dir_n
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic cap_prev_ff;
    logic [1:0] cap_wid_ff;
    logic cap_armed_ff;
    logic [31:0] ctrl_ff;
    logic [31:0] limit_ff;
    logic [31:0] compare_ff;
    logic [1:0] home_ff;
    axis_state_t state_ff;
    axis_state_t nxt_state;
    logic [15:0] oneshot_ff;
    logic [15:0] gap_ff;
    logic cmp_level_ff;
    logic cap_seen_ff;
    logic ferr_seen_ff;

    // Control fields.
    wire logic fault_shutdown_enable = ctrl_ff[0];
    wire motion_mode_t mode = motion_mode_t'(ctrl_ff[2:1]);
    wire logic stepper_axis = ctrl_ff[3];
    wire logic full_current_select = ctrl_ff[4];
    wire logic unipolar_mode = ctrl_ff[5];
    wire logic cmp_active_low = ctrl_ff[6];
    wire logic cmp_oneshot = ctrl_ff[7];
    wire logic cmp_manual = ctrl_ff[8];
    wire logic cmp_manual_level = ctrl_ff[9];
    wire logic lim_pos_en = limit_ff[0];
    wire logic lim_neg_en = limit_ff[1];
    wire stop_action_t stop_act = stop_action_t'(limit_ff[3:2]);

    wire logic fault_s = sync2_ff[0];
    wire logic home_s = sync2_ff[1];
    wire logic lim_p_s = sync2_ff[2];
    wire logic lim_n_s = sync2_ff[3];
    wire logic cap_s = sync2_ff[4];

    function automatic logic limit_trip(motion_mode_t m, logic lp, logic ln, logic mp, logic mn);
        unique case (m)
            MODE_POSITION, MODE_VELOCITY: limit_trip = (lp & mp) | (ln & mn);
            MODE_CONTOUR: limit_trip = lp | ln;
            MODE_TORQUE: limit_trip = 1'b0;
        endcase
    endfunction : limit_trip

    wire logic apb_wr = psel & penable & pwrite;
    wire logic apb_rd = psel & penable & ~pwrite;
    wire logic cmd_on = apb_wr && (paddr == `OFS_CMD) && pwdata[0];
    wire logic cmd_off = apb_wr && (paddr == `OFS_CMD) && pwdata[1];
    wire logic lim_hit = limit_trip(mode, lim_p_s & lim_pos_en, lim_n_s & lim_neg_en, move_pos, move_neg);
    wire logic fault_hit = fault_s & fault_shutdown_enable;
    wire logic axis_err = fault_hit | following_err | (lim_hit & (stop_act == STOP_OFF));

    ////////////////////////////////////////////////////////////////////////////////
    // Two stages before anything looks at the pins; metastability stays in stage one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 5'h0;
            sync2_ff <= 5'h0;
        end else begin
            sync1_ff <= {capture_in, limit_neg_in, limit_pos_in, home_in, fault_in};
            sync2_ff <= sync1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A capture needs the synchronised level high for the minimum width, which rejects glitches.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_prev_ff <= 1'b0;
            cap_wid_ff <= 2'h0;
            cap_armed_ff <= 1'b0;
            capture_strobe <= 1'b0;
        end else begin
            cap_prev_ff <= cap_s;
            capture_strobe <= 1'b0;
            if (cap_s && !cap_prev_ff) begin
                cap_armed_ff <= 1'b1;
                cap_wid_ff <= 2'h1;
            end else if (cap_s && cap_armed_ff) begin
                if (cap_wid_ff >= 2'(`CAPTURE_MIN_CYC - 1)) begin
                    capture_strobe <= 1'b1;
                    cap_armed_ff <= 1'b0;
                end else begin
                    cap_wid_ff <= cap_wid_ff + 2'h1;
                end
            end else if (!cap_s) begin
                cap_armed_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Homing always uses the dedicated home pin; there is no mapping register for it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_set <= 1'b0;
            home_ff <= 2'h0;
        end else begin
            home_ff <= {home_ff[0], home_s};
            if (stepper_axis) begin
                zero_set <= home_s & ~home_ff[0];
            end else begin
                zero_set <= index_pulse & home_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            AX_OFF: if (cmd_on && !fault_hit) nxt_state = AX_ON;
            AX_ON: begin
                if (fault_hit) nxt_state = AX_FAULTED;
                else if (cmd_off || axis_err) nxt_state = AX_OFF;
                else if (lim_hit) nxt_state = AX_STOPPING;
            end
            AX_STOPPING: begin
                if (fault_hit) nxt_state = AX_FAULTED;
                else if (cmd_off || axis_err) nxt_state = AX_OFF;
                else if (!lim_hit) nxt_state = AX_ON;
            end
            AX_FAULTED: if (!fault_s) nxt_state = AX_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= AX_OFF;
            amp_enable_n <= 1'b1;
            drive_disable_n <= 1'b0;
            stop_decel_req <= 1'b0;
            stop_abrupt_req <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            amp_enable_n <= ~(nxt_state == AX_ON || nxt_state == AX_STOPPING);
            drive_disable_n <= (nxt_state == AX_ON || nxt_state == AX_STOPPING);
            stop_decel_req <= (nxt_state == AX_STOPPING) && (stop_act == STOP_DECEL);
            stop_abrupt_req <= (nxt_state == AX_STOPPING) && (stop_act != STOP_DECEL);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Hits arriving inside the retrigger gap are dropped, so the pin never runs faster than allowed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oneshot_ff <= 16'h0;
            gap_ff <= 16'h0;
            cmp_level_ff <= 1'b0;
        end else begin
            if (gap_ff != 16'h0) gap_ff <= gap_ff - 16'h1;
            if (oneshot_ff != 16'h0) oneshot_ff <= oneshot_ff - 16'h1;
            if (compare_hit && gap_ff == 16'h0) begin
                gap_ff <= stepper_axis ? 16'(`STEP_GAP_CYC - 1) : 16'(`SERVO_GAP_CYC - 1);
                if (cmp_oneshot) oneshot_ff <= 16'(`ONESHOT_CYC);
                else cmp_level_ff <= ~cmp_level_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_out <= 1'b0;
            current_dir_n <= 1'b1;
        end else begin
            if (cmp_manual) compare_out <= cmp_manual_level;
            else compare_out <= (cmp_oneshot ? (oneshot_ff != 16'h0) : cmp_level_ff) ^ cmp_active_low;
            if (unipolar_mode && !stepper_axis) current_dir_n <= ~cmd_dir_neg;
            else current_dir_n <= ~full_current_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky event flags; a new event in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_seen_ff <= 1'b0;
            ferr_seen_ff <= 1'b0;
        end else begin
            if (capture_strobe) cap_seen_ff <= 1'b1;
            else if (apb_wr && paddr == `OFS_STATUS && pwdata[8]) cap_seen_ff <= 1'b0;
            if (following_err) ferr_seen_ff <= 1'b1;
            else if (apb_wr && paddr == `OFS_STATUS && pwdata[9]) ferr_seen_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CTRL_RESET;
            limit_ff <= `LIMIT_RESET;
            compare_ff <= `COMPARE_RESET;
        end else if (apb_wr) begin
            if (paddr == `OFS_CTRL) ctrl_ff <= {22'h0, pwdata[9:0]};
            if (paddr == `OFS_LIMIT) limit_ff <= {28'h0, pwdata[3:0]};
        end
    end

    // Zero-wait slave: ready in every access phase, error on unmapped addresses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > `OFS_HOME || paddr[1:0] != 2'b00);
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `OFS_CTRL: prdata <= ctrl_ff;
                    `OFS_LIMIT: prdata <= limit_ff;
                    `OFS_STATUS: prdata <= {23'h0, ferr_seen_ff, cap_seen_ff, cap_s, state_ff,
                        lim_n_s, lim_p_s, home_s, fault_s};
                    `OFS_COMPARE: prdata <= {31'h0, compare_out};
                    `OFS_HOME: prdata <= {31'h0, zero_set};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : axis_io_safety_logic

// ---- core/axis_io_map.svh ----
/*
 * Register offsets, reset values and timing counts for the axis I/O supervision block.
 * Assumes a 20 MHz APB clock and one axis per instance.
 */
`ifndef AXIS_IO_MAP_SVH
`define AXIS_IO_MAP_SVH

`define CLK_HZ 20000000
`define OFS_CTRL 12'h000
`define OFS_LIMIT 12'h004
`define OFS_CMD 12'h008
`define OFS_STATUS 12'h00C
`define OFS_COMPARE 12'h010
`define OFS_HOME 12'h014
`define CTRL_RESET 32'h0000_0000
`define LIMIT_RESET 32'h0000_0000
`define COMPARE_RESET 32'h0000_0000
`define CAPTURE_MIN_NS 100
`define CAPTURE_MIN_CYC ((`CAPTURE_MIN_NS * 20 + 999) / 1000)
`define ONESHOT_US 1000
`define ONESHOT_CYC ((`ONESHOT_US * (`CLK_HZ / 1000000)))
`define SERVO_RETRIG_HZ 4000
`define STEP_RETRIG_HZ 1000
`define SERVO_GAP_CYC (`CLK_HZ / `SERVO_RETRIG_HZ)
`define STEP_GAP_CYC (`CLK_HZ / `STEP_RETRIG_HZ)

`endif

// ---- core/axis_io_pkg.sv ----
/*
 * Types shared by the axis I/O supervision block.
 * Assumes the map header supplies all numeric constants.
 */
package axis_io_pkg;
    typedef enum logic [1:0] {
        MODE_POSITION = 2'b00,
        MODE_VELOCITY = 2'b01,
        MODE_CONTOUR = 2'b11,
        MODE_TORQUE = 2'b10
    } motion_mode_t;
    typedef enum logic [1:0] {
        STOP_DECEL = 2'b00,
        STOP_ABRUPT = 2'b01,
        STOP_OFF = 2'b10,
        STOP_RSVD = 2'b11
    } stop_action_t;
    typedef enum logic [1:0] {
        AX_OFF = 2'b00,
        AX_ON = 2'b01,
        AX_STOPPING = 2'b11,
        AX_FAULTED = 2'b10
    } axis_state_t;
endpackage : axis_io_pkg

// ---- tb/axis_io_safety_logic_chk.sv ----
/*
 * Port checker for the axis I/O supervision block.
 * Assumes one clock, pclk, and the asynchronous active-low reset presetn.
 */
`timescale 1ns/1ps

module axis_io_chk (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and core handshakes.
    input wire logic capture_in,
    input wire logic capture_strobe,
    input wire logic stop_decel_req,
    input wire logic stop_abrupt_req,
    input wire logic amp_enable_n,
    input wire logic drive_disable_n,
    input wire logic current_dir_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing in access phase");
    ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside an access phase");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    reset_safe_a: assert property ($rose(presetn) |-> amp_enable_n && !drive_disable_n && current_dir_n)
        else $error("outputs not safe at reset release");
    disable_pair_a: assert property (!drive_disable_n |-> amp_enable_n)
        else $error("amplifier enabled while drive disabled");
    switch_on_a: assert property ($rose(drive_disable_n) |-> !amp_enable_n)
        else $error("disable released without enable");
    capture_seen_a: assert property ($rose(capture_in) ##1 capture_in |-> ##[2:8] capture_strobe)
        else $error("short capture pulse missed");
    capture_sync_a: assert property ($rose(capture_in) |-> !capture_strobe [*2])
        else $error("capture strobe skipped the synchroniser");
    stop_exclusive_a: assert property (!(stop_decel_req && stop_abrupt_req))
        else $error("two stop actions at once");
    cover property ($fell(amp_enable_n));
    cover property (capture_strobe);
    cover property (pslverr);
endmodule : axis_io_chk

bind axis_io_safety_logic axis_io_chk axis_io_chk_inst (.*);

// ---- tb/axis_drive_model.sv ----
/*
 * Amplifier and sensor model: reports a fault after a chosen delay and makes capture pulses.
 * Assumes the bench raises fault_req and cap_req after a rising edge.
 */
`timescale 1ns/1ps

module axis_drive_model #(
    parameter int FAULT_DLY = 3,
    parameter int CAP_CYC = 2
) (
    // Clock.
    input wire logic pclk,
    // Bench commands.
    input wire logic fault_req,
    input wire logic cap_req,
    // Pins back to the controller.
    output logic fault_in,
    output logic capture_in
);
    logic [7:0] dly_ff = 8'h00;
    int cnt_ff = 0;
    ////////////////////////////////////////////////////////////////////////////
    // A slow amplifier reports late, so the delay is a parameter.
    always @(posedge pclk) begin
        dly_ff <= {dly_ff[6:0], fault_req};
    end
    assign fault_in = dly_ff[FAULT_DLY];
    // Pulses are the minimum width, one per request.
    always @(posedge pclk) begin
        if (cap_req && cnt_ff == 0) begin
            cnt_ff <= CAP_CYC;
        end else if (cnt_ff > 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    assign capture_in = (cnt_ff > 0);
endmodule : axis_drive_model

// ---- tb/axis_io_safety_logic_tb_top.sv ----
/*
 * Self-checking bench for the axis I/O supervision block.
 * Assumes the design answers APB one cycle after setup and updates pins a cycle after a write.
 */
`timescale 1ns/1ps
`include "axis_io_map.svh"

module axis_io_safety_logic_tb_top;
    import axis_io_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic fault_in, capture_in, home_in = 0, limit_pos_in = 0, limit_neg_in = 0, fault_req = 0, cap_req = 0;
    logic move_pos = 0, move_neg = 0, following_err = 0, index_pulse = 0, compare_hit = 0, cmd_dir_neg = 0;
    logic stop_decel_req, stop_abrupt_req, capture_strobe, zero_set;
    logic amp_enable_n, drive_disable_n, compare_out, current_dir_n;
    int miscompares = 0, n_checks = 0, n_zero = 0, n_cap = 0, k;
    axis_io_safety_logic axis_io_safety_logic_inst (.*);
    axis_drive_model axis_drive_model_inst (.*);
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        n_zero <= n_zero + zero_set;
        n_cap <= n_cap + capture_strobe;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            $display("ERROR apb pready expected 1 seen timeout");
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        // One idle edge keeps a following call from driving psel twice in one time step.
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask : wr
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_fault;
        chk("reset pins", {amp_enable_n, drive_disable_n, compare_out, current_dir_n}, 4'h9);
        apb(0, `OFS_CTRL, 0);
        chk("ctrl reset", rd, `CTRL_RESET);
        wr(`OFS_CTRL, 32'h0000_0001);
        wr(`OFS_CMD, 32'h0000_0001);
        wait_n(2);
        chk("switched on", {amp_enable_n, drive_disable_n}, 2'h1);
        fault_req <= 1;
        wait_n(8);
        chk("fault off", {amp_enable_n, drive_disable_n}, 2'h2);
        apb(0, `OFS_STATUS, 0);
        chk("fault bit", rd[0], 1);
        fault_req <= 0;
        wait_n(8);
        chk("stays off", {amp_enable_n, drive_disable_n}, 2'h2);
        wr(`OFS_CMD, 32'h0000_0001);
        wait_n(2);
        chk("re-enabled", {amp_enable_n, drive_disable_n}, 2'h1);
        following_err <= 1;
        wait_n(4);
        chk("error off", {amp_enable_n, drive_disable_n}, 2'h2);
        following_err <= 0;
        $display("test fault done");
    endtask : t_fault
    task automatic t_limits;
        motion_mode_t md[6] = '{MODE_POSITION, MODE_VELOCITY, MODE_CONTOUR, MODE_TORQUE, MODE_POSITION,
            MODE_POSITION};
        logic [3:0] lm[6] = '{4'h3, 4'h3, 4'h7, 4'h7, 4'hB, 4'h0};
        logic [1:0] pn[6] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2};
        logic [2:0] ex[6] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h1, 3'h0};
        move_pos <= 1;
        for (int i = 0; i < 6; i++) begin
            wr(`OFS_CMD, 32'h0000_0002);
            wr(`OFS_CTRL, 32'({md[i], 1'b0}));
            wr(`OFS_LIMIT, 32'(lm[i]));
            wr(`OFS_CMD, 32'h0000_0001);
            {limit_pos_in, limit_neg_in} <= pn[i];
            wait_n(6);
            chk("limit", {stop_decel_req, stop_abrupt_req, amp_enable_n}, ex[i]);
            {limit_pos_in, limit_neg_in} <= 2'h0;
        end
        move_pos <= 0;
        $display("test limits done");
    endtask : t_limits
    task automatic t_pins;
        wr(`OFS_CTRL, 32'h0000_0018);
        wait_n(2);
        chk("full current", current_dir_n, 0);
        k = n_zero;
        home_in <= 1;
        wait_n(6);
        chk("step zero", 32'(n_zero - k), 1);
        home_in <= 0;
        wr(`OFS_CTRL, 32'h0000_0020);
        cmd_dir_neg <= 1;
        wait_n(3);
        chk("unipolar neg", current_dir_n, 0);
        cmd_dir_neg <= 0;
        wait_n(3);
        chk("unipolar pos", current_dir_n, 1);
        k = n_zero;
        for (int h = 0; h < 2; h++) begin
            home_in <= h[0];
            wait_n(4);
            index_pulse <= 1;
            @(posedge pclk);
            index_pulse <= 0;
            wait_n(4);
            chk("index zero", 32'(n_zero - k), h);
        end
        home_in <= 0;
        $display("test pins done");
    endtask : t_pins
    task automatic t_capture;
        k = n_cap;
        cap_req <= 1;
        @(posedge pclk);
        cap_req <= 0;
        wait_n(10);
        chk("capture", 32'(n_cap - k), 1);
        apb(0, `OFS_STATUS, 0);
        chk("capture seen", rd[7], 1);
        wr(`OFS_STATUS, 32'h0000_0100);
        apb(0, `OFS_STATUS, 0);
        chk("seen cleared", rd[7], 0);
        apb(0, 12'h020, 0);
        chk("unmapped", er, 1);
        $display("test capture done");
    endtask : t_capture
    task automatic t_compare;
        wr(`OFS_CTRL, 32'h0000_0300);
        wait_n(2);
        chk("manual out", compare_out, 1);
        apb(0, `OFS_COMPARE, 0);
        chk("compare read", rd[0], 1);
        wr(`OFS_CTRL, 32'h0000_0080);
        wait_n(2);
        chk("idle low", compare_out, 0);
        compare_hit <= 1;
        @(posedge pclk);
        compare_hit <= 0;
        wait_n(3);
        chk("pulse on", compare_out, 1);
        wait_n(10000);
        chk("pulse held", compare_out, 1);
        wait_n(20000);
        chk("pulse over", compare_out, 0);
        wr(`OFS_CTRL, 32'h0000_00C0);
        wait_n(2);
        chk("active low idle", compare_out, 1);
        $display("test compare done");
    endtask : t_compare
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        wait_n(6);
        presetn <= 1;
        @(posedge pclk);
        t_fault();
        t_limits();
        t_pins();
        t_capture();
        t_compare();
        wrap_up();
    end
    // About 30000 cycles are expected; the margin covers slow answers.
    initial begin
        wait_n(60000);
        miscompares++;
        wrap_up();
    end
endmodule : axis_io_safety_logic_tb_top
